// ---- bench/apec_axis_comp_tb_top.sv ----
// self-checking bench for the axis compensation block
`timescale 1ns/1ps
`default_nettype none
module apec_axis_comp_tb_top
	import apec_pkg::*;
;
	logic			clk = 1'b0, rst_n = 1'b0, load = 1'b0, ref_cmd = 1'b0;
	logic			awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic			arvalid = 1'b0, rready = 1'b0;
	logic [ADDR_W-1:0]	awaddr = '0, araddr = '0;
	logic [DATA_W-1:0]	wdata = '0;
	logic signed [31:0]	step = '0, lpos = '0;
	logic			awready, wready, bvalid, arready, rvalid;
	logic			tick_s, tick_i, refd, upd;
	logic [1:0]		bresp, rresp, refp = '0;
	logic [DATA_W-1:0]	rdata;
	logic signed [31:0]	inc, apos, comp_pos, bl_out, tab_out;
	logic [31:0]		lfsr = 32'h1c32;
	int			mismatches, samples_checked;
	int			bl_amt, bl_step, bl_comp, bl_tgt, bl_dir, d, st, sh, k;
	bit			wrap;
	int			tv[TABLE_POINTS];
	int			amts[3] = '{10, -6, 10};
	int			steps[3] = '{4, 0, 20};
	int			pat[14] = '{5, 5, 0, -5, 0, -5, 5, 0, 5, 5, 5, -5, 0, 0};
	int			pos_a[8] = '{90, 100, 103, 111, 118, 120, 121, 130};
	int			pos_w[4] = '{126, 94, 119, 120};

	apec_axis_partner u_partner (.core_clk_i(clk), .rst_n_i(rst_n),
		.step_i(step), .load_i(load), .load_pos_i(lpos), .ref_i(ref_cmd),
		.servo_tick_o(tick_s), .ipo_tick_o(tick_i), .cmd_increment_o(inc),
		.actual_pos_o(apos), .referenced_o(refd));
	apec_axis_comp DUT (.core_clk_i(clk), .rst_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.servo_tick_i(tick_s), .ipo_tick_i(tick_i), .cmd_increment_i(inc),
		.actual_pos_i(apos), .axis_referenced_status_i(refd),
		.comp_pos_o(comp_pos), .backlash_comp_o(bl_out),
		.table_comp_o(tab_out), .table_update_o(upd));

	initial begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic int tab(input int p);
		int i;
		if (wrap) begin
			while (p < st) p += k << sh;
			while (p >= st + (k << sh)) p -= k << sh;
		end
		if (p < st) return tv[0];
		i = (p - st) >>> sh;
		if (i >= k) return tv[k];
		return tv[i] + (((tv[i+1] - tv[i]) * ((p - st) & ((1 << sh) - 1))) >>> sh);
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [12:0] a, input int v, input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && n < 60);
		bready <= 1'b0;
		check("bvalid", bvalid, 1'b1);
		check("bresp", bresp, er);
		@(posedge clk);
	endtask

	task automatic rd(input logic [12:0] a, input int v, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && n < 60);
		rready <= 1'b0;
		check("rvalid", rvalid, 1'b1);
		check("rdata", rdata, v);
		check("rresp", rresp, er);
		@(posedge clk);
	endtask

	task automatic move(input int v);
		step <= v;
		@(posedge clk iff tick_s);
	endtask

	task automatic tchk(input int p, input bit on);
		int e;
		e = on ? tab(p) : 0;
		lpos <= p;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		repeat (3) @(posedge clk iff tick_i);
		repeat (16) @(posedge clk);
		check("table", tab_out, e);
		check("position", comp_pos, p + bl_comp + e);
	endtask

	// backlash reference model, compared at every servo tick while referenced
	always @(posedge clk) begin
		refp <= {refp[0], refd};
		if (tick_s && !refp[1]) begin
			bl_comp = 0;
			bl_tgt = 0;
			bl_dir = 0;
		end else if (tick_s) begin
			check("backlash", bl_out, bl_comp);
			if (inc != 0 && bl_dir != 0 && (inc > 0) != (bl_dir > 0)) begin
				bl_tgt = (inc > 0) ? bl_amt : 0;
			end
			if (inc != 0) bl_dir = (inc > 0) ? 1 : -1;
			d = bl_tgt - bl_comp;
			if (bl_step == 0 || (d <= bl_step && d >= -bl_step)) begin
				bl_comp = bl_tgt;
			end else begin
				bl_comp += (d > 0) ? bl_step : -bl_step;
			end
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_CTRL, 0, RESP_OKAY);
		rd(OFS_TBL_POINTS, 350, RESP_OKAY);
		rd(OFS_TBL_SHIFT, 0, RESP_OKAY);
		rd(13'h040, 0, RESP_SLVERR);
		wr(OFS_STATUS, -1, RESP_OKAY);
		rd(OFS_STATUS, 0, RESP_OKAY);
		for (int c = 0; c < 3; c++) begin
			ref_cmd <= 1'b0;
			move(0);
			wr(OFS_BL_AMOUNT, amts[c], RESP_OKAY);
			wr(OFS_BL_STEP, steps[c], RESP_OKAY);
			bl_amt = amts[c];
			bl_step = steps[c];
			ref_cmd <= 1'b1;
			move(0);
			foreach (pat[i]) begin
				move(pat[i]);
			end
		end
		ref_cmd <= 1'b0;
		foreach (pat[i]) begin
			move(pat[i]);
		end
		check("unreferenced", bl_out, 0);
		ref_cmd <= 1'b1;
		move(0);
		move(-5);
		move(5);
		move(0);
		wr(OFS_TBL_START, 100, RESP_OKAY);
		wr(OFS_TBL_SHIFT, 2, RESP_OKAY);
		wr(OFS_TBL_POINTS, 6, RESP_OKAY);
		st = 100;
		sh = 2;
		k = 5;
		rd(OFS_TBL_END, 120, RESP_OKAY);
		for (int i = 0; i <= k + 1; i++) begin
			tv[i] = (i == 0 || i == k) ? 0 : (i == 3) ? 32'h0040_0000 : int'(rnd() % 512) - 256;
			wr(OFS_TABLE + ADDR_W'(4 * i), tv[i], RESP_OKAY);
		end
		wr(13'h1574, int'(rnd()), RESP_OKAY);
		wr(13'h1578, int'(rnd()), RESP_SLVERR);
		foreach (amts[i]) begin
			wr(OFS_CTRL, i * i, RESP_OKAY);
			tchk(111, 1'b0);
		end
		wr(OFS_CTRL, 5, RESP_OKAY);
		rd(OFS_STATUS, 3, RESP_OKAY);
		foreach (pos_a[i]) begin
			tchk(pos_a[i], 1'b1);
		end
		wr(OFS_CTRL, 7, RESP_OKAY);
		wrap = 1'b1;
		foreach (pos_w[i]) begin
			tchk(pos_w[i], 1'b1);
		end
		ref_cmd <= 1'b0;
		tchk(111, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire

// ---- bench/apec_axis_monitor.sv ----
// port-level assertion checker for the axis compensation block
`timescale 1ns/1ps
`default_nettype none
module apec_axis_monitor
	import apec_pkg::*;
#(
	parameter int POINTS = 350
) (
	// clock and reset
	input wire logic			core_clk_i,
	input wire logic			rst_n_i,
	// bus handshakes
	input wire logic			s_axi_awvalid_i,
	input wire logic			s_axi_awready_o,
	input wire logic			s_axi_wvalid_i,
	input wire logic			s_axi_wready_o,
	input wire logic			s_axi_bvalid_o,
	input wire logic			s_axi_bready_i,
	input wire logic			s_axi_arvalid_i,
	input wire logic			s_axi_arready_o,
	input wire logic			s_axi_rvalid_o,
	input wire logic			s_axi_rready_i,
	// axis side
	input wire logic			servo_tick_i,
	input wire logic			ipo_tick_i,
	input wire logic signed [DATA_W-1:0]	actual_pos_i,
	input wire logic			axis_referenced_status_i,
	input wire logic signed [DATA_W-1:0]	comp_pos_o,
	input wire logic signed [DATA_W-1:0]	backlash_comp_o,
	input wire logic signed [DATA_W-1:0]	table_comp_o,
	input wire logic			table_update_o
);
	default clocking mon_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// cycles since the last interpolation tick, saturating
	logic [7:0] since_ipo;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			since_ipo <= 8'hff;
		end else if (ipo_tick_i) begin
			since_ipo <= 8'h00;
		end else if (since_ipo != 8'hff) begin
			since_ipo <= since_ipo + 8'h01;
		end
	end

	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write response missing");
	a_write_release: assert property (s_axi_bvalid_o && s_axi_bready_i
		|=> !s_axi_bvalid_o)
		else $error("write response not released");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o)
		else $error("read data missing");
	a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while data pending");
	a_update_pulse: assert property (table_update_o |=> !table_update_o)
		else $error("update pulse longer than one cycle");
	a_update_delay: assert property (table_update_o |-> since_ipo >= 8'h04 && since_ipo <= 8'h1f)
		else $error("update not tied to interpolation tick");
	a_table_off: assert property (!axis_referenced_status_i [*8] |-> table_comp_o == '0 && !table_update_o)
		else $error("table correction while unreferenced");
	a_backlash_tick: assert property ($changed(backlash_comp_o) |-> $past(servo_tick_i) || $past(servo_tick_i, 2) || backlash_comp_o == '0)
		else $error("backlash changed without servo tick");
	a_comp_sum: assert property (($stable(actual_pos_i) && $stable(backlash_comp_o) && $stable(table_comp_o)) [*3] |-> comp_pos_o == actual_pos_i + backlash_comp_o + table_comp_o)
		else $error("compensated position not the sum");
endmodule

bind apec_axis_comp apec_axis_monitor #(.POINTS(POINTS)) u_monitor (
	.core_clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.servo_tick_i, .ipo_tick_i, .actual_pos_i, .axis_referenced_status_i,
	.comp_pos_o, .backlash_comp_o, .table_comp_o, .table_update_o
);
`default_nettype wire

// ---- bench/apec_axis_partner.sv ----
// position loop and encoder model driving the compensation block
`timescale 1ns/1ps
`default_nettype none
module apec_axis_partner (
	// clock and reset
	input wire logic			core_clk_i,
	input wire logic			rst_n_i,
	// bench control
	input wire logic signed [31:0]	step_i,
	input wire logic			load_i,
	input wire logic signed [31:0]	load_pos_i,
	input wire logic			ref_i,
	// toward the block
	output logic			servo_tick_o,
	output logic			ipo_tick_o,
	output logic signed [31:0]	cmd_increment_o,
	output logic signed [31:0]	actual_pos_o,
	output logic			referenced_o
);
	// servo cycle every 8 clocks, interpolation cycle every 32
	logic [4:0] phase;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase <= '0;
			servo_tick_o <= 1'b0;
			ipo_tick_o <= 1'b0;
			cmd_increment_o <= '0;
			actual_pos_o <= '0;
			referenced_o <= 1'b0;
		end else begin
			phase <= phase + 5'h01;
			servo_tick_o <= (phase[2:0] == 3'h0);
			ipo_tick_o <= (phase == 5'h04);
			referenced_o <= ref_i;
			if (phase[2:0] == 3'h0) begin
				cmd_increment_o <= step_i;
			end
			if (load_i) begin
				actual_pos_o <= load_pos_i;
			end else if (phase[2:0] == 3'h0) begin
				actual_pos_o <= actual_pos_o + step_i;
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/apec_axis_comp.sv ----
// axis backlash and interpolated table compensation with axi4-lite registers
//
// How it works
// - reversal adds backlash to actual value
// - backlash active only after referencing
// - backlash amount is signed
// - ramp backlash one step per servo tick
// - step above amount applies in one tick
// - range split into equal segments
// - linear interpolation between neighbouring points
// - each interpolation tick updates compensated position
// - positive table value drives axis negative
// - table correction is never clamped
// - table needs enable, values, referenced
// - reference lost stops table compensation
// - table holds 350 signed points
// - usable point count is configurable
// - configurable spacing between points
// - below start uses point zero
// - above end uses point k
// - wrap mode repeats table cyclically
// - out-of-range point index rejected with error; reads of table addresses answer OKAY at any index
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module apec_axis_comp
	import apec_pkg::*;
#(
	parameter int POINTS = TABLE_POINTS
) (
	// clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0]        s_axi_awaddr_i,
	input  wire logic                     s_axi_awvalid_i,
	output logic                          s_axi_awready_o,
	input  wire logic [DATA_W-1:0]        s_axi_wdata_i,
	input  wire logic [3:0]               s_axi_wstrb_i,
	input  wire logic                     s_axi_wvalid_i,
	output logic                          s_axi_wready_o,
	output logic [1:0]                    s_axi_bresp_o,
	output logic                          s_axi_bvalid_o,
	input  wire logic                     s_axi_bready_i,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]        s_axi_araddr_i,
	input  wire logic                     s_axi_arvalid_i,
	output logic                          s_axi_arready_o,
	output logic [DATA_W-1:0]             s_axi_rdata_o,
	output logic [1:0]                    s_axi_rresp_o,
	output logic                          s_axi_rvalid_o,
	input  wire logic                     s_axi_rready_i,
	// axis side
	input  wire logic                     servo_tick_i,
	input  wire logic                     ipo_tick_i,
	input  wire logic signed [DATA_W-1:0] cmd_increment_i,
	input  wire logic signed [DATA_W-1:0] actual_pos_i,
	input  wire logic                     axis_referenced_status_i,
	output logic signed [DATA_W-1:0]      comp_pos_o,
	output logic signed [DATA_W-1:0]      backlash_comp_o,
	output logic signed [DATA_W-1:0]      table_comp_o,
	output logic                          table_update_o
);

	// configuration
	logic                     table_comp_enable_flag;
	logic                     table_wrap_mode;
	logic                     table_present;
	logic signed [DATA_W-1:0] backlash_amount;
	logic        [DATA_W-1:0] backlash_step_size_setting;
	logic signed [DATA_W-1:0] table_start_position;
	logic        [SHIFT_W-1:0] table_point_spacing;
	logic        [IDX_W-1:0]  table_max_points_setting;

	// reference pin synchroniser
	logic ref_meta;
	logic ref_sync;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_meta <= 1'b0;
			ref_sync <= 1'b0;
		end else begin
			ref_meta <= axis_referenced_status_i;
			ref_sync <= ref_meta;
		end
	end

	// write channel capture
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0]        w_strb;
	logic              wr_fire;
	logic              wr_table;
	logic              wr_bad;
	logic [IDX_W-1:0]  wr_idx;

	assign wr_fire  = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_table = aw_addr >= OFS_TABLE;
	assign wr_idx   = aw_addr[IDX_W+1:2];
	assign wr_bad   = wr_table && (aw_addr[ADDR_W-2:2] >= 11'(POINTS));

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_addr         <= '0;
			w_data          <= '0;
			w_strb          <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end else begin
			s_axi_awready_o <= !aw_held && !s_axi_awready_o;
			s_axi_wready_o  <= !w_held && !s_axi_wready_o;
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] data, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// configuration registers
	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] ctrl_new;

	assign ctrl_word = {29'h0, table_present, table_wrap_mode,
		table_comp_enable_flag};
	assign ctrl_new  = merge(ctrl_word, w_data, w_strb);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			table_comp_enable_flag     <= 1'b0;
			table_wrap_mode            <= 1'b0;
			table_present              <= 1'b0;
			backlash_amount            <= '0;
			backlash_step_size_setting <= '0;
			table_start_position       <= '0;
			table_point_spacing        <= RST_SHIFT;
			table_max_points_setting   <= RST_POINTS;
		end else if (wr_fire && !wr_table) begin
			case (aw_addr)
				OFS_CTRL: begin
					table_comp_enable_flag <= ctrl_new[CTRL_EN_BIT];
					table_wrap_mode        <= ctrl_new[CTRL_WRAP_BIT];
					table_present          <= ctrl_new[CTRL_PRESENT_BIT];
				end
				OFS_BL_AMOUNT: backlash_amount <=
					merge(backlash_amount, w_data, w_strb);
				OFS_BL_STEP: backlash_step_size_setting <=
					merge(backlash_step_size_setting, w_data, w_strb);
				OFS_TBL_START: table_start_position <=
					merge(table_start_position, w_data, w_strb);
				OFS_TBL_SHIFT: begin
					table_point_spacing <= (w_data[SHIFT_W-1:0] > SHIFT_MAX) ?
						SHIFT_MAX : w_data[SHIFT_W-1:0];
				end
				OFS_TBL_POINTS: begin
					if (w_data[IDX_W-1:0] < MIN_POINTS) begin
						table_max_points_setting <= MIN_POINTS;
					end else if (w_data[IDX_W-1:0] > IDX_W'(POINTS)) begin
						table_max_points_setting <= IDX_W'(POINTS);
					end else begin
						table_max_points_setting <= w_data[IDX_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// table geometry: end point k and its position
	logic        [IDX_W-1:0] end_idx;
	logic signed [POS_W-1:0] period;
	logic signed [POS_W-1:0] end_pos;

	assign end_idx = table_max_points_setting - 9'h001;
	assign period  = POS_W'({25'h0, end_idx} << table_point_spacing);
	assign end_pos = POS_W'(table_start_position) + period;

	// backlash ramp
	apec_dir_t                last_dir;
	logic signed [DATA_W-1:0] bl_target;
	logic signed [DATA_W-1:0] bl_comp;
	logic                     inc_pos;
	logic                     inc_neg;
	logic                     reversal;
	logic signed [DATA_W-1:0] next_target;
	logic signed [DATA_W:0]   bl_diff;
	logic signed [DATA_W:0]   bl_step;

	assign inc_pos  = cmd_increment_i > 0;
	assign inc_neg  = cmd_increment_i < 0;
	assign reversal = (inc_pos && last_dir == DIR_NEG) ||
		(inc_neg && last_dir == DIR_POS);
	assign next_target = reversal ? (inc_pos ? backlash_amount : '0) :
		bl_target;
	assign bl_diff = (DATA_W+1)'(next_target) - (DATA_W+1)'(bl_comp);
	assign bl_step = {1'b0, backlash_step_size_setting};

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_dir  <= DIR_NONE;
			bl_target <= '0;
			bl_comp   <= '0;
		end else if (!ref_sync) begin
			last_dir  <= DIR_NONE;
			bl_target <= '0;
			bl_comp   <= '0;
		end else if (servo_tick_i) begin
			if (inc_pos) begin
				last_dir <= DIR_POS;
			end else if (inc_neg) begin
				last_dir <= DIR_NEG;
			end
			bl_target <= next_target;
			if (bl_step == '0 || bl_diff <= bl_step && -bl_diff <= bl_step) begin
				bl_comp <= next_target;
			end else if (bl_diff > 0) begin
				bl_comp <= DATA_W'(bl_comp + bl_step);
			end else begin
				bl_comp <= DATA_W'(bl_comp - bl_step);
			end
		end
	end

	// table lookup and interpolation
	apec_ipo_state_t          ipo_state;
	logic                     table_active;
	logic signed [POS_W-1:0]  offset;
	logic        [IDX_W-1:0]  idx_lo;
	logic        [IDX_W-1:0]  idx_hi;
	logic        [DATA_W-1:0] frac;
	logic signed [DATA_W-1:0] val_lo;
	logic signed [DATA_W-1:0] tbl_comp;
	logic        [IDX_W-1:0]  mem_raddr;
	logic        [DATA_W-1:0] mem_rdata;
	logic signed [POS_W-1:0]  seg_idx;
	logic signed [63:0]       slope;

	assign table_active = table_comp_enable_flag && table_present &&
		ref_sync;
	assign seg_idx   = offset >>> table_point_spacing;
	assign mem_raddr = (ipo_state == IPO_FETCH_HI) ? idx_hi : idx_lo;
	assign slope     = (64'(signed'(mem_rdata)) - 64'(val_lo)) *
		64'(signed'({1'b0, frac}));

	apec_point_mem #(
		.DEPTH (POINTS),
		.WIDTH (DATA_W),
		.AW    (IDX_W)
	) u_points (
		.core_clk_i (core_clk_i),
		.we_i       (wr_fire && wr_table && !wr_bad),
		.waddr_i    (wr_idx),
		.wdata_i    (w_data),
		.raddr_i    (mem_raddr),
		.rdata_o    (mem_rdata)
	);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ipo_state      <= IPO_IDLE;
			offset         <= '0;
			idx_lo         <= '0;
			idx_hi         <= '0;
			frac           <= '0;
			val_lo         <= '0;
			tbl_comp       <= '0;
			table_update_o <= 1'b0;
		end else if (!table_active) begin
			ipo_state      <= IPO_IDLE;
			tbl_comp       <= '0;
			table_update_o <= 1'b0;
		end else begin
			table_update_o <= 1'b0;
			case (ipo_state)
				IPO_IDLE: begin
					if (ipo_tick_i) begin
						offset    <= POS_W'(actual_pos_i) -
							POS_W'(table_start_position);
						ipo_state <= IPO_WRAP;
					end
				end
				IPO_WRAP: begin
					if (table_wrap_mode && offset < 0) begin
						offset <= offset + period;
					end else if (table_wrap_mode && offset >= period) begin
						offset <= offset - period;
					end else begin
						ipo_state <= IPO_FETCH_LO;
						if (offset < 0) begin
							idx_lo <= '0;
							idx_hi <= '0;
							frac   <= '0;
						end else if (offset >= period) begin
							idx_lo <= end_idx;
							idx_hi <= end_idx;
							frac   <= '0;
						end else begin
							idx_lo <= IDX_W'(seg_idx);
							idx_hi <= IDX_W'(seg_idx + 1);
							frac   <= DATA_W'(offset - (seg_idx <<<
								table_point_spacing));
						end
					end
				end
				IPO_FETCH_LO: ipo_state <= IPO_FETCH_HI;
				IPO_FETCH_HI: begin
					val_lo    <= mem_rdata;
					ipo_state <= IPO_CALC;
				end
				IPO_CALC: begin
					tbl_comp       <= DATA_W'(64'(val_lo) +
						(slope >>> table_point_spacing));
					table_update_o <= 1'b1;
					ipo_state      <= IPO_IDLE;
				end
				default: ipo_state <= IPO_IDLE;
			endcase
		end
	end

	// compensated actual value, table raises it so the loop drives negative
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			comp_pos_o      <= '0;
			backlash_comp_o <= '0;
			table_comp_o    <= '0;
		end else begin
			comp_pos_o      <= actual_pos_i + bl_comp + tbl_comp;
			backlash_comp_o <= bl_comp;
			table_comp_o    <= tbl_comp;
		end
	end

	// read channel
	logic [DATA_W-1:0] next_rdata;
	logic [1:0]        next_rresp;

	always_comb begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		case (s_axi_araddr_i)
			OFS_CTRL:       next_rdata = ctrl_word;
			OFS_BL_AMOUNT:  next_rdata = backlash_amount;
			OFS_BL_STEP:    next_rdata = backlash_step_size_setting;
			OFS_TBL_START:  next_rdata = table_start_position;
			OFS_TBL_SHIFT:  next_rdata = DATA_W'(table_point_spacing);
			OFS_TBL_POINTS: next_rdata = DATA_W'(table_max_points_setting);
			OFS_TBL_END:    next_rdata = DATA_W'(end_pos);
			OFS_STATUS: begin
				next_rdata[STAT_REF_BIT]  = ref_sync;
				next_rdata[STAT_TBL_BIT]  = table_active;
				next_rdata[STAT_RAMP_BIT] = bl_comp != bl_target;
			end
			OFS_TBL_COMP:   next_rdata = tbl_comp;
			OFS_BL_COMP:    next_rdata = bl_comp;
			default:        next_rresp = (s_axi_araddr_i >= OFS_TABLE) ?
				RESP_OKAY : RESP_SLVERR;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end else begin
			s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o;
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= next_rdata;
				s_axi_rresp_o  <= next_rresp;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ---- rtl/apec_pkg.sv ----
// shared constants and types for axis position error compensation
package apec_pkg;

	localparam int DATA_W       = 32;
	localparam int ADDR_W       = 13;
	localparam int TABLE_POINTS = 350;
	localparam int IDX_W        = 9;
	localparam int SHIFT_W      = 5;
	localparam int POS_W        = 34;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 13'h000;
	localparam logic [ADDR_W-1:0] OFS_BL_AMOUNT  = 13'h004;
	localparam logic [ADDR_W-1:0] OFS_BL_STEP    = 13'h008;
	localparam logic [ADDR_W-1:0] OFS_TBL_START  = 13'h00c;
	localparam logic [ADDR_W-1:0] OFS_TBL_SHIFT  = 13'h010;
	localparam logic [ADDR_W-1:0] OFS_TBL_POINTS = 13'h014;
	localparam logic [ADDR_W-1:0] OFS_TBL_END    = 13'h018;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 13'h01c;
	localparam logic [ADDR_W-1:0] OFS_TBL_COMP   = 13'h020;
	localparam logic [ADDR_W-1:0] OFS_BL_COMP    = 13'h024;
	localparam logic [ADDR_W-1:0] OFS_TABLE      = 13'h1000;

	// control and status bit positions
	localparam int CTRL_EN_BIT      = 0;
	localparam int CTRL_WRAP_BIT    = 1;
	localparam int CTRL_PRESENT_BIT = 2;
	localparam int STAT_REF_BIT     = 0;
	localparam int STAT_TBL_BIT     = 1;
	localparam int STAT_RAMP_BIT    = 2;

	// reset values and limits
	localparam logic [IDX_W-1:0]   RST_POINTS = 9'h15e;
	localparam logic [SHIFT_W-1:0] RST_SHIFT  = 5'h00;
	localparam logic [SHIFT_W-1:0] SHIFT_MAX  = 5'h14;
	localparam logic [IDX_W-1:0]   MIN_POINTS = 9'h002;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DIR_NONE,
		DIR_POS,
		DIR_NEG
	} apec_dir_t;

	typedef enum logic [2:0] {
		IPO_IDLE,
		IPO_WRAP,
		IPO_FETCH_LO,
		IPO_FETCH_HI,
		IPO_CALC
	} apec_ipo_state_t;

endpackage

// ---- rtl/apec_point_mem.sv ----
// interpolation point memory, one write port, registered read
`timescale 1ns/1ps
`default_nettype none
module apec_point_mem #(
	parameter int DEPTH = 350,
	parameter int WIDTH = 32,
	parameter int AW    = 9
) (
	// clock
	input  wire logic             core_clk_i,
	// write side
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// read side
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge core_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		rdata_o <= mem[raddr_i];
	end

endmodule
`default_nettype wire
